// file: verilog/i2cst_slave.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// i2c slave protocol engine with bus time-out and axi4-lite registers
// Contract
// - start is sda falling while scl high; it sets the busy flag.
// - only the master makes a start; the slave never drives one.
// - shift in 7-bit address after start, compare with own, interrupt on match.
// - the eighth bit after start is stored as the read request flag.
// - on match drive ack low on ninth clock and set match flag.
// - one interrupt from match, byte done or time-out; flags tell them apart.
// - after match hold scl low until data written (tx) or read (rx).
// - direction select bit chooses transmitter or receiver per read request flag.
// - data bytes are 8 bits, msb first, only after address ack.
// - receiver acks each byte; slave puts ack_to_send on ninth clock.
// - transmitter without ack releases sda and waits for stop.
// - bytes pass through the single data buffer register.
// - time-out counter starts on start plus match; scl fall clears it.
// - time-out when time since last scl fall exceeds programmed period.
// - time-out counting stops when a stop is seen.
// - on overflow counter stops, enable clears, flag sets, interrupt raised.
// - time-out resets bus logic and status register; other registers keep values.
// - time-out flag set only by hardware, cleared only by writing zero.
// - period is (select plus one) times 32 sub clocks.
// - stop clears the busy flag.
// - done flag low during a byte, set with interrupt at its end.
// - own address in bits 7 to 1; bit 0 reads zero.
module i2cst_slave #(
    parameter int SUB_CYCLES = i2cst_pkg::SUB_CYCLES // system cycles per sub clock
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low active
    input wire logic [i2cst_pkg::AXI_AW-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [i2cst_pkg::AXI_AW-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire i2cst_pkg::i2cst_pin_in_type pin_i, // bus line levels
    output i2cst_pkg::i2cst_pin_out_type pin_o, // bus line drives
    output logic bus_irq // one-cycle interrupt pulse
);
    import i2cst_pkg::*;

    localparam int SUB_W = $clog2(SUB_CYCLES);

    if (SUB_CYCLES < 2) begin : g_bad_param
        $error("sub clock divider must be at least 2");
    end

    // register decode, shared by read and write
    function automatic logic [2:0] reg_idx(input logic [AXI_AW-1:0] a);
        case (a)
            OFS_DATA: reg_idx = IDX_DATA;
            OFS_ADDR: reg_idx = IDX_ADDR;
            OFS_ENDB: reg_idx = IDX_ENDB;
            OFS_STAT: reg_idx = IDX_STAT;
            OFS_TOC: reg_idx = IDX_TOC;
            default: reg_idx = IDX_NONE;
        endcase
    endfunction

    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, strb_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [7:0] wdata_q, rdata_q, rd_mux;
    logic [1:0] bresp_q, rresp_q;
    logic [2:0] widx, ridx;
    logic wr_go, rd_go, wr_data, wr_addr, wr_endb, wr_stat, wr_toc, rd_data;
    logic [7:0] data_q;
    logic [6:0] own_q;
    logic [1:0] deb_q;
    logic en_q, tx_dir_q, ack_send_q, wake_q;
    logic done_q, match_q, busy_q, rw_q, rxack_q;
    logic to_en_q, to_flag_q;
    logic [TO_SEL_W-1:0] to_sel_q, to_cnt_q;
    logic [SUB_W-1:0] sub_cnt_q;
    logic [4:0] pre_cnt_q;
    logic to_act_q, to_tick, to_ovf;
    logic [1:0] raw, filt_q;
    logic [2:0] deb_cnt_q [2];
    logic [2:0] deb_len;
    logic scl_f, sda_f, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    i2cst_state_type st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, load_byte;
    logic sda_oe_q, scl_oe_q, irq_q;
    logic byte_end, addr_done, match_now, rx_done, tx_done, rel, kill;

    // axi handshakes and write strobes
    assign awready = ~aw_hold_q;
    assign wready = ~w_hold_q;
    assign arready = ~rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = {24'h000000, rdata_q};
    assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
    assign rd_go = arvalid & ~rvalid_q;
    assign widx = reg_idx(awaddr_q);
    assign ridx = reg_idx(araddr);
    assign wr_data = wr_go & strb_q & (widx == IDX_DATA);
    assign wr_addr = wr_go & strb_q & (widx == IDX_ADDR);
    assign wr_endb = wr_go & strb_q & (widx == IDX_ENDB);
    assign wr_stat = wr_go & strb_q & (widx == IDX_STAT);
    assign wr_toc = wr_go & strb_q & (widx == IDX_TOC);
    assign rd_data = rd_go & (ridx == IDX_DATA);

    // read data selection
    always_comb begin
        case (ridx)
            IDX_DATA: rd_mux = data_q;
            IDX_ADDR: rd_mux = {own_q, 1'b0};
            IDX_ENDB: rd_mux = {4'h0, deb_q, en_q, 1'b0};
            IDX_STAT: rd_mux = {done_q, match_q, busy_q, tx_dir_q, ack_send_q, rw_q, wake_q, rxack_q};
            IDX_TOC: rd_mux = {to_en_q, to_flag_q, to_sel_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // axi write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            strb_q <= 1'b0;
        end else begin
            if (awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q <= wdata[7:0];
                strb_q <= wstrb[0];
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (widx == IDX_NONE) ? RESP_DECERR : RESP_OKAY;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= (ridx == IDX_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // line debounce: a change must persist deb_len cycles
    assign raw = {pin_i.scl, pin_i.sda};
    assign deb_len = deb_q[1] ? DEB_LONG : (deb_q[0] ? DEB_SHORT : DEB_NONE);
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                filt_q[i] <= 1'b1;
                deb_cnt_q[i] <= 3'h0;
            end else if (raw[i] == filt_q[i]) begin
                deb_cnt_q[i] <= 3'h0;
            end else if (deb_cnt_q[i] + 3'h1 >= deb_len) begin
                filt_q[i] <= raw[i];
                deb_cnt_q[i] <= 3'h0;
            end else begin
                deb_cnt_q[i] <= deb_cnt_q[i] + 3'h1;
            end
        end
    end

    // previous line levels for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // bus events
    assign scl_f = filt_q[1];
    assign sda_f = filt_q[0];
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign byte_end = scl_fall & (bit_q == BITS_PER_BYTE);
    assign addr_done = (st_q == ST_ADDR) & byte_end;
    assign match_now = addr_done & (sh_q[7:1] == own_q);
    assign rx_done = (st_q == ST_RX) & byte_end;
    assign tx_done = (st_q == ST_TX) & byte_end;
    assign rel = (st_q == ST_HOLD) & (tx_dir_q ? wr_data : rd_data);
    assign load_byte = wdata_q;
    assign kill = ~aresetn | to_ovf | ~en_q;

    // protocol state machine and line drives
    always_ff @(posedge aclk) begin
        if (kill) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else if (start_det) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_f};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (match_now) begin
                        st_q <= ST_AACK;
                        sda_oe_q <= 1'b1;
                    end else if (addr_done) begin
                        st_q <= ST_WAIT;
                    end else if (rx_done) begin
                        st_q <= ST_RACK;
                        sda_oe_q <= ~ack_send_q;
                    end
                end
                ST_AACK, ST_RACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        scl_oe_q <= 1'b1;
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (rel) begin
                        scl_oe_q <= 1'b0;
                        bit_q <= 4'h0;
                        if (tx_dir_q) begin
                            sh_q <= load_byte;
                            sda_oe_q <= ~load_byte[7];
                            st_q <= ST_TX;
                        end else begin
                            st_q <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_q <= bit_q + 4'h1;
                    end
                    if (tx_done) begin
                        sda_oe_q <= 1'b0;
                        st_q <= ST_TACK;
                    end else if (scl_fall) begin
                        sda_oe_q <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b0};
                    end
                end
                ST_TACK: begin
                    if (scl_fall && rxack_q) begin
                        st_q <= ST_WAIT;
                    end else if (scl_fall) begin
                        scl_oe_q <= 1'b1;
                        st_q <= ST_HOLD;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_q <= 1'b0;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // registers kept across a time-out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= RST_DATA;
            own_q <= RST_ADDR;
            deb_q <= 2'h0;
            en_q <= 1'b0;
        end else begin
            if (rx_done) begin
                data_q <= sh_q;
            end else if (wr_data) begin
                data_q <= wdata_q;
            end
            if (wr_addr) begin
                own_q <= wdata_q[7:1];
            end
            if (wr_endb) begin
                deb_q <= wdata_q[ENDB_DEB+1:ENDB_DEB];
                en_q <= wdata_q[ENDB_EN];
            end
        end
    end

    // status and control: control bits and flags
    always_ff @(posedge aclk) begin
        if (!aresetn || to_ovf) begin
            {done_q, match_q, busy_q, tx_dir_q} <= RST_STAT[7:4];
            {ack_send_q, rw_q, wake_q, rxack_q} <= RST_STAT[3:0];
        end else begin
            if (wr_stat) begin
                tx_dir_q <= wdata_q[ST_TXDIR];
                ack_send_q <= wdata_q[ST_ACKS];
                wake_q <= wdata_q[ST_WAKE];
            end
            if (!en_q) begin
                {done_q, match_q, busy_q} <= RST_STAT[7:5];
                rw_q <= RST_STAT[ST_RW];
                rxack_q <= RST_STAT[ST_RXACK];
            end else begin
                if (start_det) begin
                    busy_q <= 1'b1;
                    match_q <= 1'b0;
                end else if (stop_det) begin
                    busy_q <= 1'b0;
                end
                if (match_now || rx_done || tx_done) begin
                    done_q <= 1'b1;
                end else if (start_det || rel) begin
                    done_q <= 1'b0;
                end
                if (match_now) begin
                    match_q <= 1'b1;
                    rw_q <= sh_q[0];
                end
                if (st_q == ST_TACK && scl_rise) begin
                    rxack_q <= sda_f;
                end
            end
        end
    end

    // single interrupt pulse from three causes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= match_now | rx_done | tx_done | to_ovf;
        end
    end

    // time-out tick: 32 sub clocks, restarted at every scl fall
    assign to_tick = (sub_cnt_q == SUB_W'(SUB_CYCLES - 1)) & (pre_cnt_q == 5'(TO_PRESCALE - 1));
    assign to_ovf = to_tick & to_act_q & to_en_q & ~scl_fall & (to_cnt_q == to_sel_q);
    always_ff @(posedge aclk) begin
        if (!aresetn || scl_fall || match_now || !to_act_q) begin
            sub_cnt_q <= '0;
            pre_cnt_q <= 5'h00;
        end else if (sub_cnt_q == SUB_W'(SUB_CYCLES - 1)) begin
            sub_cnt_q <= '0;
            pre_cnt_q <= (pre_cnt_q == 5'(TO_PRESCALE - 1)) ? 5'h00 : pre_cnt_q + 5'h01;
        end else begin
            sub_cnt_q <= sub_cnt_q + SUB_W'(1);
        end
    end

    // time-out activity and period counter
    always_ff @(posedge aclk) begin
        if (!aresetn || to_ovf || stop_det || !en_q) begin
            to_act_q <= 1'b0;
            to_cnt_q <= '0;
        end else begin
            if (match_now) begin
                to_act_q <= 1'b1;
            end
            if (scl_fall || match_now || !to_en_q) begin
                to_cnt_q <= '0;
            end else if (to_tick && to_act_q) begin
                to_cnt_q <= to_cnt_q + TO_SEL_W'(1);
            end
        end
    end

    // time-out control register; hardware set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_en_q <= 1'b0;
            to_flag_q <= 1'b0;
            to_sel_q <= RST_TO_SEL;
        end else begin
            if (wr_toc) begin
                to_en_q <= wdata_q[TOC_EN];
                to_sel_q <= wdata_q[TO_SEL_W-1:0];
            end
            if (to_ovf) begin
                to_en_q <= 1'b0;
                to_flag_q <= 1'b1;
            end else if (wr_toc && !wdata_q[TOC_FLAG]) begin
                to_flag_q <= 1'b0;
            end
        end
    end

    // pin drives: open drain, only pull low
    assign pin_o.scl_o = 1'b0;
    assign pin_o.sda_o = 1'b0;
    assign pin_o.scl_oe = scl_oe_q;
    assign pin_o.sda_oe = sda_oe_q;
    assign bus_irq = irq_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_to_after;
        !to_en_q && to_flag_q && !busy_q;
    endsequence
    sequence s_por_stat;
        done_q && !match_q && !tx_dir_q && rxack_q && st_q == ST_IDLE && !scl_oe_q;
    endsequence

    property p_start_busy;
        start_det && en_q && !to_ovf |=> busy_q;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not set busy");
    property p_no_start;
        $rose(sda_oe_q) |-> $past(!scl_f);
    endproperty
    a_no_start: assert property (p_no_start) else $error("sda driven while scl high");
    property p_match_irq;
        match_now |=> bus_irq && sda_oe_q && match_q;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match without ack or irq");
    property p_hold;
        st_q == ST_HOLD && !rel && !start_det && !stop_det && !kill |=> scl_oe_q && st_q == ST_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("scl released without buffer access");
    property p_to_ovf;
        to_ovf |=> s_to_after;
    endproperty
    a_to_ovf: assert property (p_to_ovf) else $error("time-out did not stop and flag");
    property p_to_reset;
        to_ovf |=> s_por_stat;
    endproperty
    a_to_reset: assert property (p_to_reset) else $error("status not reset on time-out");
    property p_flag_src;
        $rose(to_flag_q) |-> $past(to_ovf);
    endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag set without time-out");
    property p_to_idle;
        !to_en_q |-> !to_ovf;
    endproperty
    a_to_idle: assert property (p_to_idle) else $error("time-out while disabled");
    property p_fall_clr;
        scl_fall && en_q |=> to_cnt_q == '0;
    endproperty
    a_fall_clr: assert property (p_fall_clr) else $error("scl fall did not clear counter");
    property p_stop_free;
        stop_det |=> !busy_q;
    endproperty
    a_stop_free: assert property (p_stop_free) else $error("stop left bus busy");
endmodule

// file: verilog/i2cst_pkg.sv
// package: register map, fields, states and timing of the i2c slave
package i2cst_pkg;
    // clock and time-out timing
    localparam int CLK_HZ = 250_000_000;
    localparam int SUB_HZ = 32_000;
    localparam int SUB_CYCLES = CLK_HZ / SUB_HZ; // system cycles per sub clock
    localparam int TO_PRESCALE = 32; // sub clocks per time-out tick
    localparam int TO_SEL_W = 6;
    // register byte offsets and indices
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_ENDB = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_TOC = 8'h10;
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_ENDB = 3'h2;
    localparam logic [2:0] IDX_STAT = 3'h3;
    localparam logic [2:0] IDX_TOC = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    // reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [7:0] RST_STAT = 8'h81;
    localparam logic [TO_SEL_W-1:0] RST_TO_SEL = 6'h00;
    // field positions
    localparam int ENDB_EN = 1;
    localparam int ENDB_DEB = 2;
    localparam int ST_DONE = 7;
    localparam int ST_MATCH = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_TXDIR = 4;
    localparam int ST_ACKS = 3;
    localparam int ST_RW = 2;
    localparam int ST_WAKE = 1;
    localparam int ST_RXACK = 0;
    localparam int TOC_EN = 7;
    localparam int TOC_FLAG = 6;
    // debounce lengths in system cycles
    localparam logic [2:0] DEB_NONE = 3'h0;
    localparam logic [2:0] DEB_SHORT = 3'h2;
    localparam logic [2:0] DEB_LONG = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_HOLD, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_WAIT
    } i2cst_state_type;
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cst_pin_in_type;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } i2cst_pin_out_type;
endpackage

// file: verif/i2cst_master.sv
`timescale 1ns/1ps
// two-wire bus master model with stretch wait
module i2cst_master (
    input wire logic aclk, // system clock
    input wire logic scl, // scl wire level
    input wire logic sda, // sda wire level
    output logic scl_m = 1'b1, // low pulls scl
    output logic sda_m = 1'b1 // low pulls sda
);
    int hung = 0;
    // both lines for one half bit
    task automatic lv(input logic c, input logic d);
        scl_m <= c;
        sda_m <= d;
        repeat (8) @(posedge aclk);
    endtask
    // start when s is 1, stop when 0
    task automatic cond(input logic s);
        lv(s, s);
        lv(1'b1, 1'b0);
        lv(~s, ~s);
    endtask
    // one bit, waits while the slave holds scl
    task automatic bit_x(input logic d, output logic r);
        int t;
        lv(1'b0, d);
        scl_m <= 1'b1;
        for (t = 0; t < 999 && scl !== 1'b1; t++) @(posedge aclk);
        hung += int'(t == 999);
        lv(1'b1, d);
        r = sda;
        lv(1'b0, d);
    endtask
    // byte msb first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
            output logic k);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a, k);
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
// bench: register tasks and bus sequences
module tb_top;
    import i2cst_pkg::*;
    logic aclk = 1'b0, aresetn, awvalid, wvalid;
    logic bready, arvalid, rready;
    logic [7:0] awaddr, araddr, q8;
    logic [31:0] wdata, rdata, q;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, bus_irq, m_scl, m_sda, k;
    logic [1:0] bresp, rresp, br;
    i2cst_pin_in_type pin_i;
    i2cst_pin_out_type pin_o;
    int err_count = 0, n_tests = 0, irqs = 0, hangs = 0;
    i2cst_slave #(.SUB_CYCLES(4)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .pin_i, .pin_o, .bus_irq);
    i2cst_master m_u (.aclk, .scl(pin_i.scl), .sda(pin_i.sda), .scl_m(m_scl), .sda_m(m_sda));
    // clock, wired-and lines with pull-ups, irq count
    always #2 aclk = ~aclk;
    assign pin_i = {m_scl & ~pin_o.scl_oe, m_sda & ~pin_o.sda_oe};
    always @(posedge aclk) if (bus_irq === 1'b1) irqs <= irqs + 1;
    // counts, verdict, end
    task automatic report_and_stop();
        err_count += hangs + m_u.hung;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // compare and report
    task automatic cmp(input logic [9:0] g, input logic [9:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // axi write, bounded wait
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int t;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (t = 0; t < 99; t++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                br = bresp;
                break;
            end
        end
        bready <= 1'b0;
        hangs += int'(t == 99);
        @(posedge aclk);
    endtask
    // axi read into q, bounded wait
    task automatic rd(input logic [7:0] a);
        int t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (t = 0; t < 99; t++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        q = rdata;
        rready <= 1'b0;
        hangs += int'(t == 99);
        @(posedge aclk);
    endtask
    // read, mask, compare with response
    task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        cmp({rresp, q[7:0] & m}, {(a > OFS_TOC) ? RESP_DECERR : RESP_OKAY, e});
    endtask
    // main sequence
    initial begin
        aresetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wdata, wstrb} <= {8'h00, 8'h00, 32'h0, 4'hf};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(OFS_STAT, 8'hff, 8'h81);
        chk(OFS_TOC, 8'hff, 8'h00);
        chk(8'h20, 8'hff, 8'h00);
        wr(OFS_ENDB, 8'h02);
        wr(OFS_ADDR, 8'ha5);
        chk(OFS_ADDR, 8'hff, 8'ha4);
        wstrb <= 4'he;
        wr(OFS_ADDR, 8'h00);
        wstrb <= 4'hf;
        chk(OFS_ADDR, 8'hff, 8'ha4);
        cmp({8'h0, br}, {8'h0, RESP_OKAY});
        wr(8'h20, 8'h55);
        cmp({8'h0, br}, {8'h0, RESP_DECERR});
        m_u.cond(1'b1);
        chk(OFS_STAT, 8'h20, 8'h20);
        m_u.xfer(8'ha4, 1'b1, q8, k);
        cmp({9'h0, k}, 10'h0);
        cmp(10'(irqs), 10'h1);
        chk(OFS_STAT, 8'he4, 8'he0);
        cmp({9'h0, pin_o.scl_oe}, 10'h1);
        rd(OFS_DATA);
        chk(OFS_STAT, 8'h80, 8'h00);
        m_u.xfer(8'h3c, 1'b1, q8, k);
        cmp({9'h0, k}, 10'h0);
        chk(OFS_DATA, 8'hff, 8'h3c);
        wr(OFS_STAT, 8'h08);
        m_u.xfer(8'h81, 1'b1, q8, k);
        cmp({9'h0, k}, 10'h1);
        chk(OFS_DATA, 8'hff, 8'h81);
        m_u.cond(1'b0);
        chk(OFS_STAT, 8'h20, 8'h00);
        m_u.cond(1'b1);
        m_u.xfer(8'ha5, 1'b1, q8, k);
        chk(OFS_STAT, 8'h04, 8'h04);
        wr(OFS_STAT, 8'h10);
        wr(OFS_DATA, 8'h96);
        m_u.xfer(8'hff, 1'b0, q8, k);
        cmp({2'h0, q8}, 10'h096);
        wr(OFS_DATA, 8'h5a);
        m_u.xfer(8'hff, 1'b1, q8, k);
        cmp({2'h0, q8}, 10'h05a);
        chk(OFS_STAT, 8'h01, 8'h01);
        cmp({9'h0, pin_o.sda_oe}, 10'h0);
        m_u.cond(1'b0);
        m_u.cond(1'b1);
        m_u.xfer(8'ha6, 1'b1, q8, k);
        cmp({9'h0, k}, 10'h1);
        m_u.cond(1'b0);
        wr(OFS_STAT, 8'h00);
        wr(OFS_TOC, 8'h80);
        m_u.cond(1'b1);
        m_u.xfer(8'ha4, 1'b1, q8, k);
        repeat (90) @(posedge aclk);
        chk(OFS_TOC, 8'hff, 8'h80);
        repeat (40) @(posedge aclk);
        chk(OFS_TOC, 8'hff, 8'h40);
        chk(OFS_STAT, 8'hff, 8'h81);
        chk(OFS_ADDR, 8'hff, 8'ha4);
        cmp({9'h0, pin_o.scl_oe}, 10'h0);
        wr(OFS_TOC, 8'h40);
        chk(OFS_TOC, 8'hff, 8'h40);
        wr(OFS_TOC, 8'h00);
        chk(OFS_TOC, 8'hff, 8'h00);
        m_u.cond(1'b0);
        report_and_stop();
    end
endmodule
